// File: verif/flash_clock_security_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin nCompared++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD %0t %h %h", $time, g, e); end end
module flash_clock_security_regs_test;
  import flash_regs_pkg::*;
  logic ref_clk = 0, rst_n = 0, read = 0, write = 0, waitrequest, timebaseTick;
  logic resetSeqActive = 1, commandCompleteFlag = 0, backdoorUnlock = 0, writeWhileBusy;
  logic backdoorAllowed, unsecured;
  logic [5:0] address = 6'h00;
  logic [31:0] writedata = 32'h0000_0000, readdata, rv;
  logic [3:0] byteenable = 4'hF;
  logic [1:0] response;
  logic [2:0] wordSelect;
  nv_load_s nvLoad = '0;
  int miscompares = 0, nCompared = 0, seed = 16769, dv = 0, lk = 0, sy, ix = 0, i;
  flash_clock_security_regs u_dut (.*);
  initial forever #20 ref_clk = !ref_clk;
  task automatic summarize();
    $display("compared %0d bad %0d", nCompared, miscompares);
    if (miscompares == 0 && nCompared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge ref_clk);
    miscompares++;
    summarize();
  end
  // waitrequest and readdata are read at the edge, before that edge's own updates land
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    write <= w;
    read <= !w;
    address <= a;
    writedata <= d;
    do @(posedge ref_clk); while (waitrequest);
    rv = readdata;
    write <= 0;
    read <= 0;
    if (w && a == 6'h00 && lk == 0) dv = d[5:0];
    if (w && a == 6'h00) lk = lk | d[6];
    if (w && a == 6'h08) ix = d[2:0];
  endtask
  task automatic rd(input logic [5:0] a, input int e);
    bus(0, a, 32'h0000_0000);
    `CHK(rv, e)
  endtask
  task automatic nv(input logic f, input logic [7:0] d);
    @(posedge ref_clk);
    nvLoad <= '{1'b1, f, d};
    @(posedge ref_clk);
    nvLoad <= '0;
    sy = f ? 255 : d;
    @(negedge ref_clk);
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    rst_n <= 1;
    rd(6'h00, 0);
    nv(0, 8'($random(seed)) | 8'h3C);
    rd(6'h04, sy);
    bus(1, 6'h00, $random(seed) & 32'h0000_001F);
    rd(6'h00, 128 + dv);
    resetSeqActive <= 0;
    commandCompleteFlag <= 1;
    bus(1, 6'h00, ($random(seed) & 32'hFFFF_FF00) | 32'h0000_0058);
    bus(1, 6'h00, $random(seed) & 32'h0000_00BF);
    rd(6'h00, 192 + dv);
    repeat (70) @(posedge ref_clk);
    do @(negedge ref_clk); while (!timebaseTick);
    i = 0;
    do begin
      @(negedge ref_clk);
      i++;
    end while (!timebaseTick);
    `CHK(i, dv + 1)
    $display("test divider done");
    bus(1, 6'h04, ~sy);
    rd(6'h04, sy);
    nv(1, 8'($random(seed)));
    rd(6'h04, 255);
    for (i = 0; i < 16; i++) begin
      nv(0, 8'((i / 4) * 64 + 60 + i % 4));
      `CHK(backdoorAllowed, (sy >> 6) == 2)
      @(posedge ref_clk);
      backdoorUnlock <= 1;
      @(posedge ref_clk);
      backdoorUnlock <= 0;
      if ((sy >> 6) == 2) sy = (sy & 252) | 2;
      rd(6'h04, sy);
      `CHK(unsecured, (sy & 3) == 2)
    end
    $display("test security done");
    for (i = 0; i < 8; i++) begin
      bus(1, 6'h08, $random(seed));
      rd(6'h08, ix);
      `CHK(wordSelect, ix[2:0])
    end
    bus(1, 6'h0C, 32'hFFFF_FFFF);
    rd(6'h0C, 0);
    rd(6'h18, 0);
    `CHK(response, 2'h2)
    rd(6'h10, ((sy & 3) == 2) * 8 + ((sy >> 6) == 2) * 4 + 2);
    `CHK(writeWhileBusy, 1'b0)
    $display("test index done");
    summarize();
  end
endmodule // flash_clock_security_regs_test
`default_nettype wire

// File: verif/flash_regs_props.sv
`timescale 1ns/1ps
`default_nettype none
module flash_regs_props
  import flash_regs_pkg::*;
(
  // watched ports
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  input wire logic [31:0] readdata,
  input wire flash_regs_pkg::nv_load_s nvLoad,
  input wire logic backdoorUnlock,
  input wire logic [2:0] wordSelect,
  input wire logic backdoorAllowed,
  input wire logic unsecured
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire logic rdOk = read && !waitrequest;
  chk_idx_read: assert property (
    rdOk && address == 6'h08 |-> readdata == 32'(wordSelect)) else $error("index read");
  chk_factory_zero: assert property (
    rdOk && address == 6'h0C |-> readdata == 32'h0000_0000) else $error("factory read");
  chk_key_decode: assert property (
    rdOk && address == 6'h04 |-> backdoorAllowed == (readdata[7:6] == 2'h2)) else $error("key");
  chk_state_decode: assert property (
    rdOk && address == 6'h04 |-> unsecured == (readdata[1:0] == 2'h2)) else $error("state");
  chk_fault_secure: assert property (
    nvLoad.load && nvLoad.doubleFault |=> !backdoorAllowed && !unsecured) else $error("fault");
  chk_nv_load: assert property (
    nvLoad.load && !nvLoad.doubleFault |=> unsecured == ($past(nvLoad.data[1:0]) == 2'h2))
    else $error("load");
  chk_unlock_state: assert property (
    backdoorUnlock && backdoorAllowed && !nvLoad.load |=> unsecured) else $error("unlock");
  chk_sec_readonly: assert property (
    write && address == 6'h04 && !nvLoad.load && !backdoorUnlock |=> $stable(unsecured))
    else $error("security written");
endmodule // flash_regs_props
bind flash_clock_security_regs flash_regs_props u_props (.*);
`default_nettype wire

// File: verilog/flash_clock_security_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "flash_regs_cfg.svh"

module flash_clock_security_regs
  import flash_regs_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // avalon-mm slave
  input wire logic [`ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic [1:0] response,
  // reset-sequence load of the security byte
  input wire flash_regs_pkg::nv_load_s nvLoad,
  input wire logic resetSeqActive,
  // command engine side
  input wire logic commandCompleteFlag,
  input wire logic backdoorUnlock,
  // outputs to the engine
  output logic timebaseTick,
  output logic [2:0] wordSelect,
  output logic backdoorAllowed,
  output logic unsecured,
  output logic writeWhileBusy
);
  import flash_regs_pkg::*;

  clkdiv_s clkDiv;
  security_s security;
  logic [2:0] wordSel;
  logic [15:0] tickCount;
  logic rdPend;
  logic [3:0] wordIdx;
  logic wrLane0;
  logic mapped;

  assign wordIdx = address[5:2];
  assign wrLane0 = write && byteenable[0] && address[1:0] == 2'h0;
  assign mapped = address[1:0] == 2'h0 && wordIdx <= `TIMEBASE_IDX;

  // reads take one wait cycle so the read data comes from a flop; writes finish at once
  assign waitrequest = read && !rdPend;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdPend <= 1'b0;
    end else begin
      rdPend <= read && !rdPend;
    end
  end

  // clock divider control register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      clkDiv.loaded <= 1'b0;
      clkDiv.lock <= 1'b0;
      clkDiv.divisor <= `DIVISOR_RST;
    end else if (wrLane0 && wordIdx == `CLKDIV_IDX) begin
      // writable regardless of the command-complete flag, so reset-sequence writes land
      clkDiv.loaded <= 1'b1;
      clkDiv.lock <= clkDiv.lock | writedata[`LOCK_BIT];
      if (!clkDiv.lock) begin
        clkDiv.divisor <= writedata[`DIVISOR_W-1:0];
      end
    end
  end

  // timebase: divide by divisor+1 so band 0x00 at ~1 MHz passes every clock
  timebase_divider u_div (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .divisor(clkDiv.divisor),
    .tick(timebaseTick)
  );

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tickCount <= 16'h0000;
    end else if (timebaseTick) begin
      tickCount <= tickCount + 16'h0001;
    end
  end

  // security register: only hardware loads it, bus writes never touch it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      security <= `SECURITY_RST;
    end else if (nvLoad.load) begin
      if (nvLoad.doubleFault) begin
        security <= `SECURITY_ALL_SET;
      end else begin
        security <= nvLoad.data;
      end
    end else if (backdoorUnlock && backdoorAllowed) begin
      security.protState <= `STATE_UNSECURED;
    end
  end

  assign backdoorAllowed = security.keyEnable == `KEY_ENABLED;
  assign unsecured = security.protState == `STATE_UNSECURED;

  // word index register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wordSel <= `WORDSEL_RST;
    end else if (wrLane0 && wordIdx == `WORDIDX_IDX) begin
      wordSel <= writedata[2:0];
    end
  end
  assign wordSelect = wordSel;

  // sticky flag for software writing while a command runs outside reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      writeWhileBusy <= 1'b0;
    end else if (write && !commandCompleteFlag && !resetSeqActive) begin
      writeWhileBusy <= 1'b1;
    end else if (wrLane0 && wordIdx == `CMDSTAT_IDX && writedata[0]) begin
      writeWhileBusy <= 1'b0;
    end
  end

  // read data and response registered on the wait cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      readdata <= 32'h0000_0000;
      response <= 2'h0;
    end else if (read && !rdPend) begin
      response <= mapped ? 2'h0 : 2'h2;
      readdata <= 32'h0000_0000;
      if (mapped) begin
        case (wordIdx)
          `CLKDIV_IDX: readdata[7:0] <= clkDiv;
          `SECURITY_IDX: readdata[7:0] <= security;
          `WORDIDX_IDX: readdata[7:0] <= {5'h00, wordSel};
          `FACTORY_IDX: readdata[7:0] <= 8'h00;
          `CMDSTAT_IDX: readdata[7:0] <= {4'h0, unsecured, backdoorAllowed,
                                          commandCompleteFlag, writeWhileBusy};
          `TIMEBASE_IDX: readdata[15:0] <= tickCount;
          default: readdata <= 32'h0000_0000;
        endcase
      end
    end else if (write) begin
      response <= mapped ? 2'h0 : 2'h2;
    end
  end

endmodule // flash_clock_security_regs
`default_nettype wire

// File: verilog/flash_regs_cfg.svh
`ifndef FLASH_REGS_CFG_SVH
`define FLASH_REGS_CFG_SVH

// register word indexes (offsets 0..3 are word indexes, byte address = 4 * index)
`define CLKDIV_IDX 4'h0
`define SECURITY_IDX 4'h1
`define WORDIDX_IDX 4'h2
`define FACTORY_IDX 4'h3
// own registers
`define CMDSTAT_IDX 4'h4
`define TIMEBASE_IDX 4'h5
`define ADDR_W 6

// clock divider fields
`define LOADED_BIT 7
`define LOCK_BIT 6
`define DIVISOR_W 6

// security fields
`define KEY_ENABLED 2'h2
`define STATE_UNSECURED 2'h2
`define SECURITY_ALL_SET 8'hFF

// reset values
`define DIVISOR_RST 6'h00
`define WORDSEL_RST 3'h0
`define SECURITY_RST 8'hFF

`endif

// File: verilog/flash_regs_pkg.sv
package flash_regs_pkg;

  typedef struct packed {
    logic [7:6] keyEnable;
    logic [5:2] reservedNv;
    logic [1:0] protState;
  } security_s;

  typedef struct packed {
    logic load;
    logic doubleFault;
    logic [7:0] data;
  } nv_load_s;

  typedef struct packed {
    logic loaded;
    logic lock;
    logic [5:0] divisor;
  } clkdiv_s;

endpackage

// File: verilog/timebase_divider.sv
`timescale 1ns/1ps
`default_nettype none
`include "flash_regs_cfg.svh"

module timebase_divider (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // control
  input wire logic [`DIVISOR_W-1:0] divisor,
  // one-cycle pulse every divisor+1 clocks
  output logic tick
);

  logic [`DIVISOR_W-1:0] count;

  // no restart on divisor change; count is compared with the current divisor each clock, so a smaller value wraps at once
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 6'h00;
      tick <= 1'b0;
    end else if (count >= divisor) begin
      count <= 6'h00;
      tick <= 1'b1;
    end else begin
      count <= count + 6'h01;
      tick <= 1'b0;
    end
  end

endmodule // timebase_divider
`default_nettype wire
